// *** logic/fantp_pkg.sv ***
package fantp_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_TEST_REQ = 8'h1C;
  localparam logic [7:0] ADDR_PRESENT = 8'h1D;
  localparam logic [7:0] ADDR_TEST_EN = 8'h1E;
  localparam logic [7:0] ADDR_CFG1 = 8'h21;
  localparam logic [7:0] ADDR_CFG2 = 8'h22;
  localparam logic [7:0] ADDR_CFG3 = 8'h23;
  localparam logic [7:0] ADDR_CFG4 = 8'h24;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_TEST_REQ = 8'h00;
  localparam logic [7:0] RST_PRESENT = 8'h00;
  localparam logic [7:0] RST_TEST_EN = 8'h00;
  localparam logic [7:0] RST_CFG1 = 8'h11;
  localparam logic [7:0] RST_CFG2 = 8'h31;
  localparam logic [7:0] RST_CFG3 = 8'h51;
  localparam logic [7:0] RST_CFG4 = 8'h71;
  localparam logic [31:0] RST_CFG_ALL = {RST_CFG4, RST_CFG3, RST_CFG2, RST_CFG1};

  // ==========================================================
  // timing: clock 4 ns, millisecond tick derived from it
  localparam int CLK_PERIOD_PS = 32'h0000_0FA0;  // 4000 ps
  localparam int MS_PS = 32'h3B9A_CA00;  // 1 ms in ps
  localparam int MS_CYCLES = MS_PS / CLK_PERIOD_PS;
  // timeout figures in ms
  localparam logic [14:0] TMO_NONE_MS = 15'h0000;
  localparam logic [14:0] TMO_100_MS = 15'h0064;
  localparam logic [14:0] TMO_250_MS = 15'h00FA;
  localparam logic [14:0] TMO_400_MS = 15'h0190;
  localparam logic [14:0] TMO_667_MS = 15'h029B;
  localparam logic [14:0] TMO_1000_MS = 15'h03E8;
  localparam logic [14:0] TMO_2000_MS = 15'h07D0;
  localparam logic [14:0] TMO_32000_MS = 15'h7D00;
  // ramp step period in ms; code 000 then needs about 35 s for 33..100 %
  localparam logic [9:0] RAMP_STEP_MS = 10'h0CD;
  localparam logic [9:0] RAMP_SLOW_MUL = 10'h004;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    SRC_LOCAL = 3'h0,
    SRC_REM1 = 3'h1,
    SRC_REM2 = 3'h2,
    SRC_REM3 = 3'h3,
    SRC_OFF = 3'h4,
    SRC_MAX_LR3 = 3'h5,
    SRC_MAX_ALL = 3'h6,
    SRC_MANUAL = 3'h7
  } fantp_src_e;

  // gray steps idle -> run -> done; done -> idle flips both bits
  typedef enum logic [1:0] {
    T_IDLE = 2'h0,
    T_RUN = 2'h1,
    T_DONE = 2'h3
  } fantp_test_e;

  typedef struct packed {
    logic [2:0] control_source_select;
    logic output_polarity_invert;
    logic ramp_stretch;
    logic [2:0] spin_timeout;
  } fantp_cfg_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } fantp_bus_s;

  // timeout code to milliseconds, 0 means none
  function automatic logic [14:0] fantp_tmo_ms(input logic [2:0] code);
    logic [14:0] ms;
    ms = TMO_NONE_MS;
    unique case (code)
      3'h0: ms = TMO_NONE_MS;
      3'h1: ms = TMO_100_MS;
      3'h2: ms = TMO_250_MS;
      3'h3: ms = TMO_400_MS;
      3'h4: ms = TMO_667_MS;
      3'h5: ms = TMO_1000_MS;
      3'h6: ms = TMO_2000_MS;
      3'h7: ms = TMO_32000_MS;
    endcase
    return ms;
  endfunction

  // ramp rate code to duty slots added per step
  function automatic logic [7:0] fantp_ramp_step(input logic [2:0] code);
    logic [7:0] st;
    st = 8'h01;
    unique case (code)
      3'h0: st = 8'h01;
      3'h1: st = 8'h02;
      3'h2: st = 8'h03;
      3'h3: st = 8'h05;
      3'h4: st = 8'h08;
      3'h5: st = 8'h0C;
      3'h6: st = 8'h18;
      3'h7: st = 8'h30;
    endcase
    return st;
  endfunction

endpackage

// *** logic/fantp_chan.sv ***
`timescale 1ns/10ps
// one pwm channel: source pick, acoustic ramp, pwm with polarity
module fantp_chan (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ms_tick,
  input wire fantp_pkg::fantp_cfg_s cfg,
  input wire logic ea_en,
  input wire logic [2:0] ea_rate,
  input wire logic [3:0][7:0] temp_demand,
  input wire logic [7:0] manual_duty,
  input wire logic hold,
  output logic pwm_pin,
  output logic [7:0] duty
);
  import fantp_pkg::*;

  typedef struct packed {
    logic [7:0] duty;
    logic [9:0] ramp_cnt;
    logic [7:0] pwm_cnt;
    logic pin;
  } fantp_chan_s;

  fantp_chan_s q_reg;
  fantp_chan_s q_next;
  logic [7:0] target;
  logic [9:0] period;
  logic [8:0] sum;

  // ==========================================================
  // target duty from the selected source
  always_comb begin
    target = 8'h00;
    unique case (fantp_src_e'(cfg.control_source_select))
      SRC_LOCAL, SRC_REM1, SRC_REM2, SRC_REM3: begin
        target = temp_demand[cfg.control_source_select[1:0]];
      end
      SRC_OFF: target = 8'h00;
      SRC_MAX_LR3: begin
        target = (temp_demand[0] > temp_demand[3]) ? temp_demand[0] : temp_demand[3];
      end
      SRC_MAX_ALL: begin
        target = temp_demand[0];
        for (int i = 1; i < 4; i++) begin
          if (temp_demand[i] > target) begin
            target = temp_demand[i];
          end
        end
      end
      SRC_MANUAL: target = manual_duty;
    endcase
    if (hold) begin
      target = 8'h00;  // fan freewheels while tested
    end
  end

  // ==========================================================
  // ramp and pwm; only rises are slowed, falls follow at once
  always_comb begin
    q_next = q_reg;
    period = cfg.ramp_stretch ? 10'(RAMP_STEP_MS * RAMP_SLOW_MUL) : RAMP_STEP_MS;
    sum = {1'b0, q_reg.duty} + {1'b0, fantp_ramp_step(ea_rate)};
    q_next.pwm_cnt = q_reg.pwm_cnt + 8'h01;
    if (!ea_en || target <= q_reg.duty) begin
      q_next.duty = target;
      q_next.ramp_cnt = 10'h000;
    end else if (ms_tick) begin
      if (q_reg.ramp_cnt >= period - 10'h001) begin
        q_next.ramp_cnt = 10'h000;
        q_next.duty = (sum > {1'b0, target}) ? target : sum[7:0];
      end else begin
        q_next.ramp_cnt = q_reg.ramp_cnt + 10'h001;
      end
    end
    q_next.pin = (q_reg.pwm_cnt < q_reg.duty) ^ cfg.output_polarity_invert;
  end

  // state register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign pwm_pin = q_reg.pin;
  assign duty = q_reg.duty;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  sequence s_held;
    hold [*3];
  endsequence

  chk_off_code: assert property (cfg.control_source_select == SRC_OFF |=> q_reg.duty == 8'h00)
    else $error("off source left duty nonzero");
  chk_hold_idle: assert property (s_held ##0 $stable(cfg) |-> pwm_pin == cfg.output_polarity_invert)
    else $error("held channel not at inactive level");
  chk_ramp_period: assert property (ea_en |-> q_reg.ramp_cnt < 10'(RAMP_STEP_MS * RAMP_SLOW_MUL))
    else $error("ramp counter beyond stretched period");
endmodule

// *** logic/fantp_regs.sv ***
`timescale 1ns/10ps
// fan test and pwm configuration register bank with channel logic
module fantp_regs #(
  parameter int TICK_CYCLES = fantp_pkg::MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire fantp_pkg::fantp_bus_s bus,
  output logic [7:0] rd_data,
  input wire logic sw_reset,
  input wire logic lock_set,
  input wire logic [3:0][7:0] temp_demand,
  input wire logic [3:0][7:0] manual_duty,
  input wire logic [3:0] ea_en,
  input wire logic [3:0][2:0] ea_rate,
  output logic [3:0] pwm_pin,
  output logic [3:0][7:0] pwm_duty,
  output logic [7:0] test_active,
  output logic [7:0] fan_present,
  output logic reg_locked
);
  import fantp_pkg::*;

  typedef struct packed {
    logic [7:0] test_req;
    logic [7:0] present;
    logic [7:0] test_en;
    fantp_cfg_s [3:0] cfg;
    logic locked;
    fantp_test_e [7:0] tst;
    logic [7:0][14:0] tcnt;
    logic [17:0] tick_cnt;
    logic tick;
    logic [7:0] rdata;
  } fantp_top_s;

  localparam logic [17:0] TICK_LAST = 18'(TICK_CYCLES - 1);

  fantp_top_s q_reg;
  fantp_top_s q_next;
  logic wr_ok;
  logic wr_req;
  logic [7:0] act;
  logic [3:0] hold;
  logic [14:0] limit;

  // ==========================================================
  // write qualification: lock blocks every write until power-on
  assign wr_ok = bus.wr && !q_reg.locked;
  assign wr_req = wr_ok && bus.addr == ADDR_TEST_REQ;

  // ==========================================================
  // next state
  always_comb begin
    q_next = q_reg;
    limit = TMO_NONE_MS;
    // millisecond time base shared by tests and ramps
    q_next.tick = (q_reg.tick_cnt == TICK_LAST);
    q_next.tick_cnt = q_next.tick ? 18'h00000 : q_reg.tick_cnt + 18'h00001;
    // lock is sticky; only the async reset releases it
    if (lock_set) begin
      q_next.locked = 1'b1;
    end
    // register writes
    if (wr_ok) begin
      unique case (bus.addr)
        ADDR_TEST_REQ: q_next.test_req = bus.wdata & q_reg.test_en;
        ADDR_PRESENT: q_next.present = bus.wdata;
        ADDR_TEST_EN: q_next.test_en = bus.wdata;
        ADDR_CFG1: q_next.cfg[0] = bus.wdata;
        ADDR_CFG2: q_next.cfg[1] = bus.wdata;
        ADDR_CFG3: q_next.cfg[2] = bus.wdata;
        ADDR_CFG4: q_next.cfg[3] = bus.wdata;
        default: q_next.present = q_reg.present;
      endcase
    end
    // per-fan test sequence; fan k is driven by channel k/2
    for (int k = 0; k < 8; k++) begin
      limit = fantp_tmo_ms(q_reg.cfg[k / 2].spin_timeout);
      unique case (q_reg.tst[k])
        T_IDLE: begin
          if (q_reg.test_req[k] && q_reg.test_en[k]) begin
            q_next.tst[k] = T_RUN;
            q_next.tcnt[k] = 15'h0000;
          end else if (q_reg.test_req[k] && !wr_req) begin
            q_next.test_req[k] = 1'b0;
          end
        end
        T_RUN: begin
          if (!q_next.test_req[k]) begin
            q_next.tst[k] = T_IDLE;  // aborted by a write of 0
          end else if (q_reg.tcnt[k] >= limit) begin
            q_next.tst[k] = T_DONE;
          end else if (q_reg.tick) begin
            q_next.tcnt[k] = q_reg.tcnt[k] + 15'h0001;
          end
        end
        T_DONE: begin
          q_next.tst[k] = T_IDLE;
          // a request written in this same cycle wins over the clear
          if (!(wr_req && bus.wdata[k])) begin
            q_next.test_req[k] = 1'b0;
          end
        end
        default: q_next.tst[k] = T_IDLE;
      endcase
    end
    // software reset restores defaults unless locked
    if (sw_reset && !q_reg.locked) begin
      q_next.test_req = RST_TEST_REQ;
      q_next.present = RST_PRESENT;
      q_next.test_en = RST_TEST_EN;
      q_next.cfg = RST_CFG_ALL;
      for (int k = 0; k < 8; k++) begin
        q_next.tst[k] = T_IDLE;
      end
    end
    // read data, one cycle after the strobe; unmapped reads as zero
    q_next.rdata = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        ADDR_TEST_REQ: q_next.rdata = q_reg.test_req;
        ADDR_PRESENT: q_next.rdata = q_reg.present;
        ADDR_TEST_EN: q_next.rdata = q_reg.test_en;
        ADDR_CFG1: q_next.rdata = q_reg.cfg[0];
        ADDR_CFG2: q_next.rdata = q_reg.cfg[1];
        ADDR_CFG3: q_next.rdata = q_reg.cfg[2];
        ADDR_CFG4: q_next.rdata = q_reg.cfg[3];
        default: q_next.rdata = 8'h00;
      endcase
    end
  end

  // state register; configs come up on their own sources
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q_reg <= '0;
      q_reg.cfg <= RST_CFG_ALL;
    end else begin
      q_reg <= q_next;
    end
  end

  // ==========================================================
  // channels; a channel idles while either of its fans is tested
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      act[k] = (q_reg.tst[k] != T_IDLE);
    end
    for (int c = 0; c < 4; c++) begin
      hold[c] = act[2 * c] | act[2 * c + 1];
    end
  end

  for (genvar c = 0; c < 4; c++) begin : g_chan
    fantp_chan u_chan (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .ms_tick(q_reg.tick),
      .cfg(q_reg.cfg[c]),
      .ea_en(ea_en[c]),
      .ea_rate(ea_rate[c]),
      .temp_demand(temp_demand),
      .manual_duty(manual_duty[c]),
      .hold(hold[c]),
      .pwm_pin(pwm_pin[c]),
      .duty(pwm_duty[c])
    );
  end

  assign rd_data = q_reg.rdata;
  assign test_active = act;
  assign fan_present = q_reg.present;
  assign reg_locked = q_reg.locked;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  sequence s_cfg1_write;
    wr_ok && bus.addr == ADDR_CFG1 && !sw_reset;
  endsequence

  chk_req_gated: assert property (wr_req |=> (q_reg.test_req & $past(bus.wdata & ~q_reg.test_en)) == 8'h00)
    else $error("request set without its enable");
  chk_lock_holds: assert property (q_reg.locked && bus.wr |=> $stable(q_reg.cfg) && $stable(q_reg.present))
    else $error("locked register changed by a write");
  chk_lock_sticky: assert property (q_reg.locked |=> q_reg.locked)
    else $error("lock released without power-on reset");
  chk_cfg_write: assert property (s_cfg1_write |=> q_reg.cfg[0] == $past(bus.wdata))
    else $error("config write not stored");
  chk_test_clear: assert property (q_reg.tst[0] == T_DONE && !wr_req && !sw_reset |=> !q_reg.test_req[0])
    else $error("finished test left its request set");
  chk_no_timeout: assert property (q_reg.tst[3] == T_RUN && q_reg.cfg[1].spin_timeout == 3'h0
                                   && !wr_req && !sw_reset |=> q_reg.tst[3] == T_DONE)
    else $error("zero timeout did not end test");
  chk_tmo_bound: assert property (q_reg.tst[0] == T_RUN |-> q_reg.tcnt[0] <= fantp_tmo_ms(q_reg.cfg[0].spin_timeout))
    else $error("test ran past its timeout");
  chk_sw_reset: assert property (sw_reset && !q_reg.locked |=> q_reg.cfg[1] == RST_CFG2
                                 && q_reg.test_en == RST_TEST_EN && q_reg.test_req == RST_TEST_REQ)
    else $error("software reset did not restore defaults");
  chk_read_back: assert property (bus.rd && bus.addr == ADDR_PRESENT |=> rd_data == $past(q_reg.present))
    else $error("read data mismatch");
  chk_test_hold: assert property (q_reg.tst[5] == T_RUN |-> hold[2])
    else $error("channel not idled during its fan test");
endmodule

// *** tb/fantp_fan_model.sv ***
`timescale 1ns/10ps
// ==========================================================
// fan drive sense: on-time of the pwm pin per 256-clock window
module fantp_fan_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic pwm_pin,
  output logic [8:0] on_count
);
  logic [7:0] win_reg;
  logic [8:0] acc_reg;

  // window equals the pwm period, so any phase gives the exact on-time
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      win_reg <= 8'h00;
      acc_reg <= 9'h000;
      on_count <= 9'h000;
    end else begin
      win_reg <= win_reg + 8'h01;
      if (win_reg == 8'hFF) begin
        on_count <= acc_reg + 9'(pwm_pin);
        acc_reg <= 9'h000;
      end else begin
        acc_reg <= acc_reg + 9'(pwm_pin);
      end
    end
  end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/10ps
module tb;
  import fantp_pkg::*;
  // short tick keeps timeouts and ramp steps to a few thousand clocks
  localparam int TK = 4;
  logic clk_sys, rst_b, sw_reset, lock_set, reg_locked;
  fantp_bus_s bus;
  logic [7:0] rd_data, test_active, fan_present, d, t;
  logic [3:0][7:0] temp_demand, manual_duty, pwm_duty;
  logic [3:0] ea_en, pwm_pin;
  logic [3:0][2:0] ea_rate;
  logic [8:0] on_count;
  logic [31:0] seed;
  int n_fail, checked, i, c;
  logic [7:0] adr [7] = '{ADDR_TEST_REQ, ADDR_PRESENT, ADDR_TEST_EN, ADDR_CFG1, ADDR_CFG2,
    ADDR_CFG3, ADDR_CFG4};
  logic [7:0] rsv [7] = '{RST_TEST_REQ, RST_PRESENT, RST_TEST_EN, RST_CFG1, RST_CFG2,
    RST_CFG3, RST_CFG4};

  fantp_regs #(.TICK_CYCLES(TK)) fantp_regs_i (.clk_sys(clk_sys), .rst_b(rst_b), .bus(bus),
    .rd_data(rd_data), .sw_reset(sw_reset), .lock_set(lock_set), .temp_demand(temp_demand),
    .manual_duty(manual_duty), .ea_en(ea_en), .ea_rate(ea_rate), .pwm_pin(pwm_pin),
    .pwm_duty(pwm_duty), .test_active(test_active), .fan_present(fan_present),
    .reg_locked(reg_locked));
  fantp_fan_model fantp_fan_model_i (.clk_sys(clk_sys), .rst_b(rst_b), .pwm_pin(pwm_pin[1]),
    .on_count(on_count));

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic int tmo(input logic [2:0] k);
    int ms [8] = '{0, 100, 250, 400, 667, 1000, 2000, 32000};
    return ms[k];
  endfunction

  function automatic logic [7:0] exp_duty(input logic [2:0] k, input logic [3:0][7:0] td,
    input logic [7:0] man);
    logic [7:0] m01, m23;
    m01 = (td[0] > td[1]) ? td[0] : td[1];
    m23 = (td[2] > td[3]) ? td[2] : td[3];
    case (k)
      3'h4: return 8'h00;
      3'h5: return (td[0] > td[3]) ? td[0] : td[3];
      3'h6: return (m01 > m23) ? m01 : m23;
      3'h7: return man;
      default: return td[k[1:0]];
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1 chk(32'(rd_data), 32'(exp));
  endtask

  // one-cycle pulse on the lock input (lk high) or the software reset
  task automatic pulse(input logic lk);
    @(posedge clk_sys);
    if (lk) begin
      lock_set <= 1'b1;
    end else begin
      sw_reset <= 1'b1;
    end
    @(posedge clk_sys);
    lock_set <= 1'b0;
    sw_reset <= 1'b0;
  endtask

  // fan k runs its test on channel k/2; measure how long it stays active
  task automatic run_test(input int k, input logic [2:0] code);
    wr(ADDR_CFG1 + 8'(k / 2), {3'h7, 2'b00, code});
    wr(ADDR_TEST_REQ, 8'h01 << k);
    c = 0;
    while (test_active[k] !== 1'b1 && c < 10) begin
      @(posedge clk_sys);
      #1 c++;
    end
    chk(32'(test_active[k]), 32'h1);
    c = 0;
    while (test_active[k] === 1'b1 && c < 20000) begin
      @(posedge clk_sys);
      #1 c++;
    end
    // tick phase is free, so the end may come one cycle before the nominal span
    chk(32'(c >= tmo(code) * TK - 1 && c <= tmo(code) * TK + 4), 32'h1);
    rchk(ADDR_TEST_REQ, 8'h00);
  endtask

  task automatic wait_change(output int n);
    t = pwm_duty[0];
    n = 0;
    while (pwm_duty[0] === t && n < 8000) begin
      @(posedge clk_sys);
      #1 n++;
    end
  endtask

  // gap between two ramp steps, plain or stretched
  task automatic ramp_gap(input logic s);
    manual_duty[0] <= 8'h00;
    ea_en[0] <= 1'b1;
    ea_rate[0] <= 3'h0;
    wr(ADDR_CFG1, {3'h7, 1'b0, s, 3'h1});
    repeat (4) @(posedge clk_sys);
    manual_duty[0] <= 8'hFF;
    wait_change(c);
    wait_change(c);
    i = int'(RAMP_STEP_MS) * TK * (s ? int'(RAMP_SLOW_MUL) : 1);
    chk(32'(c >= i - 2 && c <= i + 2), 32'h1);
  endtask

  task automatic stop_test();
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // clock, watchdog, main sequence
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial begin
    #(4 * 60000);
    n_fail++;
    stop_test();
  end

  initial begin
    rst_b = 1'b0;
    bus = '0;
    sw_reset = 1'b0;
    lock_set = 1'b0;
    temp_demand = '0;
    manual_duty = '0;
    ea_en = '0;
    ea_rate = '0;
    seed = 32'h1b738aca;
    n_fail = 0;
    checked = 0;
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (i = 0; i < 7; i++) rchk(adr[i], rsv[i]);
    rchk(8'h20, 8'h00);
    // random contents, test request left alone since the loop starts past it
    for (i = 1; i < 7; i++) begin
      seed = lfsr(seed);
      if (i == 1) d = seed[7:0];
      wr(adr[i], seed[7:0]);
      rchk(adr[i], seed[7:0]);
    end
    chk(32'(fan_present), 32'(d));
    pulse(1'b0);
    for (i = 0; i < 7; i++) rchk(adr[i], rsv[i]);
    wr(ADDR_TEST_EN, 8'hFE);
    wr(ADDR_TEST_REQ, 8'h01);
    rchk(ADDR_TEST_REQ, 8'h00);
    chk(32'(test_active), 32'h0);
    wr(ADDR_TEST_EN, 8'hFF);
    run_test(0, 3'h1);
    run_test(5, 3'h2);
    run_test(3, 3'h0);
    // every source code on channel two, ramp off so duty follows at once
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      temp_demand <= {seed[7:0], seed[15:8], seed[23:16], seed[31:24]};
      manual_duty[1] <= seed[19:12];
      wr(ADDR_CFG2, {i[2:0], 5'h01});
      repeat (4) @(posedge clk_sys);
      #1 chk(32'(pwm_duty[1]), 32'(exp_duty(i[2:0], temp_demand, manual_duty[1])));
    end
    // polarity seen through the fan's on-time, zero duty included
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      d = (i < 2) ? 8'h00 : seed[7:0];
      manual_duty[1] <= d;
      wr(ADDR_CFG2, {3'h7, i[0], 4'h1});
      repeat (600) @(posedge clk_sys);
      #1 chk(32'(on_count), i[0] ? 32'h100 - 32'(d) : 32'(d));
    end
    ramp_gap(1'b0);
    ramp_gap(1'b1);
    // lock: writes and software reset are both ignored
    pulse(1'b1);
    #1 chk(32'(reg_locked), 32'h1);
    wr(ADDR_CFG3, 8'hAA);
    wr(ADDR_PRESENT, 8'h5A);
    pulse(1'b0);
    // channel three still holds what the fan five test wrote there
    rchk(ADDR_CFG3, {3'h7, 2'b00, 3'h2});
    rchk(ADDR_PRESENT, 8'h00);
    stop_test();
  end
endmodule
